// [rtl/rgt_defines.svh]
// Constants for the real-time gain tuning supervisor
// Contract
// - Settings 0 and 7 disable, 1-6 enable
// - Tuning setting resets to value one
// - 3,6 sharp; 2,5 gradual; 1,4 little change
// - Notch only in mode 2, setting 1-3,7
// - New setting applies at power-up or energize
// - Estimate resonance from speed vibration, set notch
// - Active tuning updates gains, inertia, notch frequency
// - Active tuning forces the fixed switching values
// - Active tuning rejects writes to tuned parameters
// - Save request copies tuning results to memory
// - Inertia and notch saved every 30 minutes; code does so only while tuning is active
`ifndef RGT_DEFINES_SVH
`define RGT_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RGT_OFF_TUNE_SET   8'h00
`define RGT_OFF_STIFFNESS  8'h04
`define RGT_OFF_CTRL_MODE  8'h08
`define RGT_OFF_STATUS     8'h0C
`define RGT_OFF_INERTIA    8'h10
`define RGT_OFF_NOTCH      8'h14
`define RGT_OFF_SAVE       8'h18
`define RGT_OFF_GAIN_BASE  8'h40
`define RGT_OFF_FIX_BASE   8'h80

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RGT_TUNE_SET_RST   3'h1
`define RGT_STIFF_RST      4'h4
`define RGT_MODE_RST       2'h0
`define RGT_MODE_HIGH_POS  2'h2
`define RGT_INERTIA_RST    16'h0064
`define RGT_NOTCH_RST      16'h0000
`define RGT_GAIN_RST       16'h0000

// Values forced while tuning is active
`define RGT_FIX_VFF        16'h012C
`define RGT_FIX_FF_FILT    16'h0032
`define RGT_FIX_G2_ACT     16'h0001
`define RGT_FIX_SW_MODE    16'h000A
`define RGT_FIX_SW_DELAY   16'h001E
`define RGT_FIX_SW_LEVEL   16'h0032
`define RGT_FIX_SW_HYST    16'h0021
`define RGT_FIX_SW_TIME    16'h0014

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RGT_CLK_HZ         125000000
`define RGT_SAVE_MIN       30
`define RGT_SAVE_CYC       (64'd60 * `RGT_SAVE_MIN * `RGT_CLK_HZ)

`endif

// [rtl/rgt_pkg.sv]
// Types shared by the real-time gain tuning supervisor
package rgt_pkg;

   typedef enum logic [1:0] {
      RGT_INERTIA_NONE,
      RGT_INERTIA_LITTLE,
      RGT_INERTIA_GRADUAL,
      RGT_INERTIA_SHARP
   } rgt_inertia_mode_t;

   typedef enum {
      RGT_SV_IDLE,
      RGT_SV_RUN
   } rgt_save_state_t;

   // One word toward nonvolatile memory
   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
      logic [15:0] data;
   } rgt_nv_wr_t;

   // Status word as software sees it
   typedef struct packed {
      logic       save_busy;
      logic       servo_on;
      logic       notch_on;
      logic       rt_active;
      logic [2:0] applied;
   } rgt_status_t;

endpackage

// [rtl/rgt_top.sv]
// Real-time gain tuning supervisor with APB register access
`include "rgt_defines.svh"

module rgt_top
   import rgt_pkg::*;
#(
   parameter int    N_GAIN    = 10,
   parameter int    N_FIX     = 8,
   parameter int    DW        = 16,
   parameter longint SAVE_CYC = `RGT_SAVE_CYC
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 servo_on_pin,
   input  wire logic                 vib_sign_pin,
   input  wire logic                 est_valid,
   input  wire logic [DW-1:0]        est_inertia,
   input  wire logic [N_GAIN*DW-1:0] est_gain,
   input  wire logic                 nv_load_valid,
   input  wire logic [DW-1:0]        nv_load_inertia,
   input  wire logic [DW-1:0]        nv_load_notch,
   output rgt_nv_wr_t                nv_wr,
   input  wire logic                 nv_wr_ready,
   output logic                      rt_active,
   output logic                      notch_enable,
   output rgt_inertia_mode_t         inertia_mode,
   output logic [DW-1:0]             notch_coef,
   output logic [N_GAIN*DW-1:0]      gain_out,
   output logic [N_FIX*DW-1:0]       fix_out
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [2:0]      tune_set;
   logic [3:0]      stiffness;
   logic [1:0]      ctrl_mode;
   logic [2:0]      applied;
   logic [DW-1:0]   inertia_ratio;
   logic [DW-1:0]   notch_freq;
   logic            apply_init;
   logic            save_pend;
   logic [63:0]     save_timer;
   logic            periodic_pend;
   logic [1:0]      servo_sync;
   logic            servo_q;
   logic [1:0]      vib_sync;
   logic            vib_q;
   logic [DW-1:0]   half_cnt;
   rgt_save_state_t sv_state;
   logic [3:0]      sv_idx;
   logic [3:0]      sv_last;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        acc;
   logic        wr_go;
   logic [31:0] rd_data;
   logic        rd_hit;
   logic        tuned_addr;
   logic        wr_err;
   logic        gain_hit;
   logic        fix_hit;
   logic [3:0]  reg_idx;
   logic        energize;
   logic        take_set;
   logic        next_active;
   logic        save_req;
   logic        period_tick;
   logic        vib_edge;
   rgt_status_t status;

   // Transfer completes on the edge where the slave shows ready
   assign acc     = psel & penable;
   assign wr_go   = ce & acc & pready & pwrite & ~pslverr;
   assign reg_idx = paddr[5:2];
   assign gain_hit = (paddr[7:6] == 2'h1) && (32'(reg_idx) < N_GAIN)
                     && (paddr[1:0] == 2'h0);
   assign fix_hit  = (paddr[7:6] == 2'h2) && (32'(reg_idx) < N_FIX)
                     && (paddr[1:0] == 2'h0);
   assign tuned_addr = gain_hit || fix_hit
                       || paddr == `RGT_OFF_INERTIA
                       || paddr == `RGT_OFF_NOTCH;
   assign wr_err = pwrite & rt_active & tuned_addr;

   // Energize edge, taken once after the synchroniser
   assign energize = servo_sync[1] & ~servo_q;
   assign take_set = apply_init | energize;
   assign next_active = (tune_set != 3'h0) && (tune_set != 3'h7);
   assign save_req = wr_go && paddr == `RGT_OFF_SAVE && pwdata[0];
   assign period_tick = (save_timer == 64'(SAVE_CYC - 1));
   assign vib_edge = vib_sync[1] ^ vib_q;

   assign status.save_busy = (sv_state == RGT_SV_RUN);
   assign status.servo_on  = servo_sync[1];
   assign status.notch_on  = notch_enable;
   assign status.rt_active = rt_active;
   assign status.applied   = applied;

   // Read multiplexer and address check
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (gain_hit) begin
         rd_data = 32'(gain_out[reg_idx*DW +: DW]);
      end else if (fix_hit) begin
         rd_data = 32'(fix_out[reg_idx*DW +: DW]);
      end else begin
         unique case (paddr)
            `RGT_OFF_TUNE_SET:  rd_data = 32'(tune_set);
            `RGT_OFF_STIFFNESS: rd_data = 32'(stiffness);
            `RGT_OFF_CTRL_MODE: rd_data = 32'(ctrl_mode);
            `RGT_OFF_STATUS:    rd_data = 32'(status);
            `RGT_OFF_INERTIA:   rd_data = 32'(inertia_ratio);
            `RGT_OFF_NOTCH:     rd_data = 32'(notch_freq);
            `RGT_OFF_SAVE:      rd_data = 32'(status.save_busy);
            default:            rd_hit  = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB answer: one wait state, data and error registered
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= acc & ~pready;
         if (acc & ~pready) begin
            pslverr <= ~rd_hit | wr_err;
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Operator settings
   // ----------------------------------------------------------------
   // Pending setting is only stored; it acts at the next energize
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tune_set  <= `RGT_TUNE_SET_RST;
         stiffness <= `RGT_STIFF_RST;
         ctrl_mode <= `RGT_MODE_RST;
      end else if (wr_go) begin
         if (paddr == `RGT_OFF_TUNE_SET) begin
            tune_set <= pwdata[2:0];
         end
         if (paddr == `RGT_OFF_STIFFNESS) begin
            stiffness <= pwdata[3:0];
         end
         if (paddr == `RGT_OFF_CTRL_MODE) begin
            ctrl_mode <= pwdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and energize edge
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         servo_sync <= 2'b00;
         servo_q    <= 1'b0;
         vib_sync   <= 2'b00;
         vib_q      <= 1'b0;
      end else if (ce) begin
         servo_sync <= {servo_sync[0], servo_on_pin};
         servo_q    <= servo_sync[1];
         vib_sync   <= {vib_sync[0], vib_sign_pin};
         vib_q      <= vib_sync[1];
      end
   end

   // ----------------------------------------------------------------
   // Applied setting and derived modes
   // ----------------------------------------------------------------
   // First enabled cycle after reset counts as power-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apply_init   <= 1'b1;
         applied      <= 3'h0;
         rt_active    <= 1'b0;
         inertia_mode <= RGT_INERTIA_NONE;
      end else if (ce) begin
         apply_init <= 1'b0;
         if (take_set) begin
            applied   <= tune_set;
            rt_active <= next_active;
            unique case (tune_set)
               3'h1, 3'h4: inertia_mode <= RGT_INERTIA_LITTLE;
               3'h2, 3'h5: inertia_mode <= RGT_INERTIA_GRADUAL;
               3'h3, 3'h6: inertia_mode <= RGT_INERTIA_SHARP;
               default:    inertia_mode <= RGT_INERTIA_NONE;
            endcase
         end
      end
   end

   // Mode may change at any time, so the notch follows it directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notch_enable <= 1'b0;
      end else if (ce) begin
         notch_enable <= (ctrl_mode == `RGT_MODE_HIGH_POS)
                         && ((applied >= 3'h1 && applied <= 3'h3)
                             || applied == 3'h7);
      end
   end

   // ----------------------------------------------------------------
   // Resonance estimate from speed vibration
   // ----------------------------------------------------------------
   // Half-period of the vibration in clocks; it is the notch
   // coefficient. Below about 950 hertz the count saturates.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt <= '0;
      end else if (ce) begin
         if (vib_edge) begin
            half_cnt <= '0;
         end else if (half_cnt != '1) begin
            half_cnt <= half_cnt + 1'b1;
         end
      end
   end

   // Notch frequency: tuned value, restored value, or software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notch_freq <= `RGT_NOTCH_RST;
         notch_coef <= `RGT_NOTCH_RST;
      end else if (ce) begin
         notch_coef <= notch_freq;
         if (nv_load_valid) begin
            notch_freq <= nv_load_notch;
         end else if (notch_enable && vib_edge) begin
            notch_freq <= half_cnt;
         end else if (wr_go && paddr == `RGT_OFF_NOTCH) begin
            notch_freq <= pwdata[DW-1:0];
         end
      end
   end

   // Inertia ratio from the estimator while tuning is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inertia_ratio <= `RGT_INERTIA_RST;
      end else if (ce) begin
         if (nv_load_valid) begin
            inertia_ratio <= nv_load_inertia;
         end else if (rt_active && est_valid) begin
            inertia_ratio <= est_inertia;
         end else if (wr_go && paddr == `RGT_OFF_INERTIA) begin
            inertia_ratio <= pwdata[DW-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Gain sets and forced switching values
   // ----------------------------------------------------------------
   function automatic logic [DW-1:0] fix_val(input int i);
      unique case (i)
         0:       fix_val = `RGT_FIX_VFF;
         1:       fix_val = `RGT_FIX_FF_FILT;
         2:       fix_val = `RGT_FIX_G2_ACT;
         3:       fix_val = `RGT_FIX_SW_MODE;
         4:       fix_val = `RGT_FIX_SW_DELAY;
         5:       fix_val = `RGT_FIX_SW_LEVEL;
         6:       fix_val = `RGT_FIX_SW_HYST;
         default: fix_val = `RGT_FIX_SW_TIME;
      endcase
   endfunction

   for (genvar g = 0; g < N_GAIN; g++) begin : g_gain
      // Both gain sets follow the estimator while active
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gain_out[g*DW +: DW] <= `RGT_GAIN_RST;
         end else if (ce) begin
            if (rt_active && est_valid) begin
               gain_out[g*DW +: DW] <= est_gain[g*DW +: DW];
            end else if (wr_go && gain_hit && 32'(reg_idx) == g) begin
               gain_out[g*DW +: DW] <= pwdata[DW-1:0];
            end
         end
      end
   end

   for (genvar f = 0; f < N_FIX; f++) begin : g_fix
      // Values are pinned every cycle while active
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fix_out[f*DW +: DW] <= fix_val(f);
         end else if (ce) begin
            if (rt_active) begin
               fix_out[f*DW +: DW] <= fix_val(f);
            end else if (wr_go && fix_hit && 32'(reg_idx) == f) begin
               fix_out[f*DW +: DW] <= pwdata[DW-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Nonvolatile save
   // ----------------------------------------------------------------
   // Free-running interval timer for the periodic save
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         save_timer <= 64'h0;
      end else if (ce) begin
         save_timer <= period_tick ? 64'h0 : save_timer + 64'h1;
      end
   end

   // Requests wait while a save runs; a new one wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         save_pend     <= 1'b0;
         periodic_pend <= 1'b0;
      end else if (ce) begin
         if (save_req) begin
            save_pend <= 1'b1;
         end else if (sv_state == RGT_SV_IDLE) begin
            save_pend <= 1'b0;
         end
         if (period_tick && rt_active) begin
            periodic_pend <= 1'b1;
         end else if (sv_state == RGT_SV_IDLE && !save_pend) begin
            periodic_pend <= 1'b0;
         end
      end
   end

   // Walks words: 0 inertia, 1 notch, then the gains
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sv_state <= RGT_SV_IDLE;
         sv_idx   <= 4'h0;
         sv_last  <= 4'h0;
         nv_wr    <= '0;
      end else if (ce) begin
         unique case (sv_state)
            RGT_SV_IDLE: begin
               if (save_pend || periodic_pend) begin
                  sv_state <= RGT_SV_RUN;
                  sv_idx   <= 4'h0;
                  sv_last  <= save_pend ? 4'(N_GAIN + 1) : 4'h1;
                  nv_wr.valid <= 1'b1;
                  nv_wr.addr  <= 8'h00;
                  nv_wr.data  <= inertia_ratio;
               end
            end
            RGT_SV_RUN: begin
               if (nv_wr_ready) begin
                  if (sv_idx == sv_last) begin
                     sv_state    <= RGT_SV_IDLE;
                     nv_wr.valid <= 1'b0;
                  end else begin
                     sv_idx     <= sv_idx + 4'h1;
                     nv_wr.addr <= 8'(sv_idx + 4'h1);
                     nv_wr.data <= (sv_idx == 4'h0) ? notch_freq
                                   : gain_out[(sv_idx - 4'h1)*DW +: DW];
                  end
               end
            end
         endcase
      end
   end

endmodule

// [tb/rgt_checker.sv]
// Concurrent checks on the tuning supervisor top ports
module rgt_checker
   import rgt_pkg::*;
#(
   parameter int N_FIX = 8,
   parameter int DW    = 16
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               servo_on_pin,
   input wire rgt_nv_wr_t         nv_wr,
   input wire logic               nv_wr_ready,
   input wire logic               rt_active,
   input wire rgt_inertia_mode_t  inertia_mode,
   input wire logic [N_FIX*DW-1:0] fix_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   localparam logic [127:0] FIXV = {16'h0014, 16'h0021, 16'h0032,
      16'h001E, 16'h000A, 16'h0001, 16'h0032, 16'h012C};
   logic       wr_done;
   logic [2:0] quiet;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr_done = psel && penable && pready && pwrite;
   // Quiet time of the energize pin, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 3'h0;
      end else if ($changed(servo_on_pin)) begin
         quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
         quiet <= quiet + 3'h1;
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   property p_rt_mode;
      rt_active == (inertia_mode != RGT_INERTIA_NONE);
   endproperty
   a_rt_mode: assert property (p_rt_mode)
      else $error("tuning flag and estimation mode disagree");
   property p_fixed;
      rt_active && $past(rt_active) |-> fix_out == FIXV;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("switching values not forced while tuning");
   property p_apply;
      quiet == 3'h7 |-> $stable(rt_active) && $stable(inertia_mode);
   endproperty
   a_apply: assert property (p_apply)
      else $error("setting changed without an energize edge");
   property p_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer not one wait state and one cycle");
   property p_reject;
      wr_done && rt_active && (paddr inside {[8'h40:8'h64],
         [8'h80:8'h9C], 8'h10, 8'h14}) |-> pslverr;
   endproperty
   a_reject: assert property (p_reject)
      else $error("write to tuned value not refused");
   property p_accept;
      wr_done && !rt_active && paddr == 8'h40 |-> !pslverr;
   endproperty
   a_accept: assert property (p_accept)
      else $error("gain write refused while tuning off");
   property p_nv_hold;
      nv_wr.valid && !nv_wr_ready |=>
         nv_wr.valid && $stable(nv_wr.addr) && $stable(nv_wr.data);
   endproperty
   a_nv_hold: assert property (p_nv_hold)
      else $error("memory word dropped before acceptance");
   property p_save_start;
      wr_done && paddr == 8'h18 && pwdata[0] && !nv_wr.valid
         |-> ##[1:3] nv_wr.valid;
   endproperty
   a_save_start: assert property (p_save_start)
      else $error("save request did not start a write");
   property p_ascend;
      nv_wr.valid && nv_wr_ready && nv_wr.addr == 8'h00
         |=> nv_wr.valid && nv_wr.addr == 8'h01;
   endproperty
   a_ascend: assert property (p_ascend)
      else $error("saved words out of order");
   c_save: cover property (nv_wr.valid && nv_wr_ready);
   c_reject: cover property (wr_done && pslverr);
   c_apply: cover property ($rose(rt_active));
endmodule

bind rgt_top rgt_checker #(.N_FIX(N_FIX), .DW(DW)) chk (.*);

// [tb/rgt_nv_model.sv]
// Nonvolatile memory model taking words from the supervisor
module rgt_nv_model
   import rgt_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       slow,
   input  wire rgt_nv_wr_t nv_wr,
   output logic            nv_wr_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:15];
   logic [1:0]  div;
   int          n_words;
   // Slow mode takes one word in three, like a busy array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 2'h0;
         nv_wr_ready <= 1'h0;
      end else begin
         div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
         nv_wr_ready <= !slow || div == 2'h2;
      end
   end
   // Count accepted words so periodic saves can be seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_words <= 0;
      end else if (nv_wr.valid && nv_wr_ready) begin
         n_words <= n_words + 1;
      end
   end
   // Store each accepted word at its address
   always_ff @(posedge pclk) begin
      if (nv_wr.valid && nv_wr_ready) begin
         mem[nv_wr.addr[3:0]] <= nv_wr.data;
      end
   end
endmodule

// [tb/realtime_gain_tuning_control_test.sv]
// Self-checking bench for the tuning supervisor
module realtime_gain_tuning_control_test
   import rgt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [127:0] FIXV = {16'h0014, 16'h0021, 16'h0032,
      16'h001E, 16'h000A, 16'h0001, 16'h0032, 16'h012C};
   logic              pclk, presetn, ce, psel, penable, pwrite;
   logic              servo_on_pin, vib_sign_pin, est_valid, slow;
   logic              nv_load_valid, nv_wr_ready, pready, pslverr;
   logic              rt_active, notch_enable, err;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [15:0]       est_inertia, nv_load_inertia, nv_load_notch, notch_coef;
   logic [159:0]      est_gain, gain_out;
   logic [127:0]      fix_out;
   rgt_nv_wr_t        nv_wr;
   rgt_inertia_mode_t inertia_mode;
   int                n_mismatch = 0;
   int                num_checks = 0;
   int                cyc = 0;

   rgt_top #(.SAVE_CYC(200)) uut (.*);
   rgt_nv_model nvm (.*);

   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end
   // Hang guard: the whole run needs under a thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp, input string w);
      apb(1'h0, a, 32'h0);
      chk(w, rd, exp);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_reset;
      for (int i = 0; i < 8; i++)
         chk("fixed", fix_out[16*i +: 16], FIXV[16*i +: 16]);
      rdchk(8'h00, 32'h1, "setting");
      rdchk(8'h0C, 32'h09, "status");
      rdchk(8'h10, 32'h64, "inertia");
      rdchk(8'h1C, 32'h0, "unmapped");
      chk("unmapped error", err, 1'h1);
      chk("mode", inertia_mode, RGT_INERTIA_LITTLE);
      $display("test reset done");
   endtask
   task t_restore;
      @(posedge pclk);
      nv_load_valid <= 1'h1;
      nv_load_inertia <= 16'h0123;
      nv_load_notch <= 16'h0045;
      @(posedge pclk);
      nv_load_valid <= 1'h0;
      rdchk(8'h10, 32'h0123, "restored inertia");
      rdchk(8'h14, 32'h0045, "restored notch");
      $display("test restore done");
   endtask
   // Estimator results land in gains and inertia, writes refused
   task t_estimate;
      @(posedge pclk);
      est_valid <= 1'h1;
      @(posedge pclk);
      est_valid <= 1'h0;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 10; i++)
         chk("gain", gain_out[16*i +: 16], est_gain[16*i +: 16]);
      rdchk(8'h10, {16'h0, est_inertia}, "inertia");
      apb(1'h1, 8'h40, 32'h5555);
      chk("gain write error", err, 1'h1);
      apb(1'h1, 8'h10, 32'h7);
      chk("inertia write error", err, 1'h1);
      apb(1'h1, 8'h84, 32'h7);
      chk("fixed write error", err, 1'h1);
      rdchk(8'h40, {16'h0, est_gain[15:0]}, "gain kept");
      $display("test estimate done");
   endtask
   // Full save against a stalling memory, then periodic saves
   task t_save;
      int n;
      slow <= 1'h1;
      apb(1'h1, 8'h18, 32'h1);
      repeat (3) @(posedge pclk);
      n = 0;
      do begin
         apb(1'h0, 8'h18, 32'h0);
         n++;
      end while (rd[0] !== 1'h0 && n < 100);
      for (int i = 0; i < 12; i++)
         chk("saved", nvm.mem[i], i == 0 ? 16'h00C8 : i == 1 ? 16'h0045
            : est_gain[16*(i-2) +: 16]);
      n = nvm.n_words;
      repeat (260) @(posedge pclk);
      chk("periodic", 32'(nvm.n_words - n >= 2), 32'h1);
      slow <= 1'h0;
      $display("test save done");
   endtask
   task t_notch;
      apb(1'h1, 8'h08, 32'h2);
      repeat (3) @(posedge pclk);
      chk("notch on", notch_enable, 1'h1);
      repeat (8) begin
         repeat (20) @(posedge pclk);
         vib_sign_pin <= ~vib_sign_pin;
      end
      repeat (4) @(posedge pclk);
      apb(1'h0, 8'h14, 32'h0);
      chk("notch period", 32'(rd >= 19 && rd <= 21), 32'h1);
      chk("notch coefficient", notch_coef, rd);
      $display("test notch done");
   endtask
   // Every setting, written while de-energized, applied on energize
   task t_modes;
      logic       prev;
      logic [1:0] m;
      for (int v = 0; v < 8; v++) begin
         prev = rt_active;
         servo_on_pin <= 1'h0;
         apb(1'h1, 8'h00, 32'(v));
         repeat (6) @(posedge pclk);
         chk("held", rt_active, prev);
         servo_on_pin <= 1'h1;
         repeat (8) @(posedge pclk);
         m = (v == 0 || v == 7) ? 2'h0 : 2'((v - 1) % 3 + 1);
         chk("active", rt_active, v != 0 && v != 7);
         chk("mode", inertia_mode, m);
         chk("notch", notch_enable, v inside {1, 2, 3, 7});
      end
      apb(1'h1, 8'h40, 32'h5555);
      chk("free write error", err, 1'h0);
      rdchk(8'h40, 32'h5555, "free gain");
      apb(1'h1, 8'h04, 32'h3);
      rdchk(8'h04, 32'h3, "stiffness");
      $display("test modes done");
   endtask

   initial begin
      ce = 1'h1;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      servo_on_pin = 1'h0;
      vib_sign_pin = 1'h0;
      est_valid = 1'h0;
      slow = 1'h0;
      nv_load_valid = 1'h0;
      nv_load_inertia = 16'h0;
      nv_load_notch = 16'h0;
      est_inertia = 16'h00C8;
      for (int i = 0; i < 10; i++)
         est_gain[16*i +: 16] = 16'(16'h0101 * (i + 1));
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
      t_reset();
      t_restore();
      t_estimate();
      t_save();
      t_notch();
      t_modes();
      complete_run();
   end
endmodule
